/* cwd_consts.vh */
// Purpose: Constants for the configuration word decoder
// Assumes: 14-bit configuration words, three words
// Notes:   Definitions only
`ifndef CWD_CONSTS_VH
`define CWD_CONSTS_VH
`define CWD_WORD_W        14
`define CWD_ADDR_W        2
`define CWD_IDX_ONE       2'h0
`define CWD_IDX_TWO       2'h1
`define CWD_IDX_THREE     2'h2
`define CWD_IDX_STATUS    2'h3
// Word one fields
`define CWD_OSC_LO        0
`define CWD_OSC_HI        2
`define CWD_POWER_UP_DELAY_TIMER_BIT      5
`define CWD_PROT_BIT      7
`define CWD_PROT_MASK     14'h0080
`define CWD_BOR_LO        9
`define CWD_BOR_HI        10
// Unimplemented positions forced to one
`define CWD_W1_UNIMP      14'h0118
`define CWD_W2_UNIMP      14'h0078
`define CWD_W3_UNIMP      14'h0080
// Erased values: all ones, word three bits 13:12 zero
`define CWD_W1_ERASED     14'h3fff
`define CWD_W2_ERASED     14'h3fff
`define CWD_W3_ERASED     14'h0fff
// Word three fields
`define CWD_WPS_LO        0
`define CWD_WPS_HI        4
`define CWD_WEN_LO        5
`define CWD_WEN_HI        6
`define CWD_WWS_LO        8
`define CWD_WWS_HI        10
`define CWD_WCS_LO        11
`define CWD_WCS_HI        13
// Oscillator codes
`define CWD_OSC_ECH       3'h7
`define CWD_OSC_ECM       3'h6
`define CWD_OSC_ECL       3'h5
`define CWD_OSC_INT       3'h4
`define CWD_OSC_HS        3'h2
// Clock source outputs
`define CWD_CLK_EXT       3'h0
`define CWD_CLK_INT       3'h1
`define CWD_CLK_XTAL      3'h2
`define CWD_CLK_BAD       3'h7
// Watchdog clock codes
`define CWD_WCS_SOFT      3'h7
`define CWD_WCS_MF        3'h1
`define CWD_WCS_LF        3'h0
`define CWD_WSRC_MF       2'h0
`define CWD_WSRC_LF       2'h1
`define CWD_WSRC_SOFT     2'h2
`define CWD_WSRC_BAD      2'h3
// Watchdog enable codes
`define CWD_WEN_ALWAYS    2'h3
`define CWD_WEN_AWAKE     2'h2
`define CWD_WEN_SOFT      2'h1
// Window codes, 110 maps to 111
`define CWD_WWS_OPEN      3'h7
`define CWD_WWS_OPEN_ALT  3'h6
`define CWD_WWS_LAST      3'h5
// Period codes
`define CWD_WPS_SOFT      5'h1f
`define CWD_WPS_SOFT_POR  5'h0b
`define CWD_WPS_MAX       5'h12
`define CWD_WPS_MIN       5'h00
`define CWD_EXP_BASE      5'h05
`endif

/* cwd_fuse_store.v */
// Purpose: Holds the three configuration words as erasable fuse storage
// Assumes: Programming and erase strobes come from the programming port
// Notes:   Read data comes out of a register
`timescale 1ns/1ns
`default_nettype none
`include "cwd_consts.vh"
module cwd_fuse_store (
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    prog_we,
  input  wire [`CWD_ADDR_W-1:0]  prog_addr,
  input  wire [`CWD_WORD_W-1:0]  prog_data,
  input  wire                    bulk_erase,
  input  wire [`CWD_ADDR_W-1:0]  rd_addr,
  output reg  [`CWD_WORD_W-1:0]  rd_data_ff,
  output wire [`CWD_WORD_W-1:0]  word_one,
  output wire [`CWD_WORD_W-1:0]  word_two,
  output wire [`CWD_WORD_W-1:0]  word_three
);
  reg [`CWD_WORD_W-1:0] mem_ff [0:2];
  reg [`CWD_WORD_W-1:0] nxt_rd;

  // Unimplemented bits forced to one on every read
  assign word_one   = mem_ff[0] | `CWD_W1_UNIMP;
  assign word_two   = mem_ff[1] | `CWD_W2_UNIMP;
  assign word_three = mem_ff[2] | `CWD_W3_UNIMP;

  // Fuse contents are non-volatile, so reset does not touch them
  always @(posedge clk) begin
    if (bulk_erase) begin
      mem_ff[0] <= `CWD_W1_ERASED;
      mem_ff[1] <= `CWD_W2_ERASED;
      mem_ff[2] <= `CWD_W3_ERASED;
    end else if (prog_we && prog_addr != `CWD_IDX_STATUS) begin
      // Words are rewritten whole, but protection only ever tightens
      mem_ff[prog_addr] <= (prog_addr == `CWD_IDX_ONE) ?
                           (prog_data & (mem_ff[0] | ~`CWD_PROT_MASK)) : prog_data;
    end
  end

  always @* begin
    case (rd_addr)
      `CWD_IDX_ONE:   nxt_rd = word_one;
      `CWD_IDX_TWO:   nxt_rd = word_two;
      `CWD_IDX_THREE: nxt_rd = word_three;
      default:        nxt_rd = {`CWD_WORD_W{1'b0}};
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      rd_data_ff <= {`CWD_WORD_W{1'b0}};
    end else begin
      rd_data_ff <= nxt_rd;
    end
  end

  initial begin
    mem_ff[0] = `CWD_W1_ERASED;
    mem_ff[1] = `CWD_W2_ERASED;
    mem_ff[2] = `CWD_W3_ERASED;
  end
endmodule
`default_nettype wire

/* cwd_wdt_decode.v */
// Purpose: Decodes the watchdog clock, window and period fields of word three
// Assumes: Inputs come straight from the fuse store; outputs are latched in the top module
// Notes:   Purely combinational
`timescale 1ns/1ns
`default_nettype none
`include "cwd_consts.vh"
module cwd_wdt_decode (
  input  wire [2:0] clk_fuse,
  input  wire [2:0] win_fuse,
  input  wire [1:0] en_fuse,
  input  wire [4:0] per_fuse,
  output reg  [1:0] wdt_src,
  output wire       win_soft,
  output wire [2:0] win_por,
  output wire       per_soft,
  output wire [4:0] per_por,
  output reg  [4:0] per_exp
);
  // 110 behaves like 111: fully open and software owned
  assign win_soft = (win_fuse == `CWD_WWS_OPEN) || (win_fuse == `CWD_WWS_OPEN_ALT);
  assign win_por  = win_soft ? `CWD_WWS_OPEN : win_fuse;
  assign per_soft = (per_fuse == `CWD_WPS_SOFT);
  assign per_por  = per_soft ? `CWD_WPS_SOFT_POR :
                    (per_fuse > `CWD_WPS_MAX) ? `CWD_WPS_MIN : per_fuse;

  always @* begin
    per_exp = per_por + `CWD_EXP_BASE;
    case (clk_fuse)
      `CWD_WCS_SOFT: wdt_src = `CWD_WSRC_SOFT;
      `CWD_WCS_MF:   wdt_src = `CWD_WSRC_MF;
      `CWD_WCS_LF:   wdt_src = `CWD_WSRC_LF;
      default:       wdt_src = `CWD_WSRC_BAD;
    endcase
  end
endmodule
`default_nettype wire

/* cwd_config_decoder.v */
// Purpose: Configuration word decoder feeding clock, reset and watchdog units
// Assumes: Inputs synchronous to REF_CLK; fuse programming via PROG port
// Notes:   Words read only over the register port
`timescale 1ns/1ns
`default_nettype none
`include "cwd_consts.vh"
module cwd_config_decoder (
  input  wire                    REF_CLK,
  input  wire                    RST,
  input  wire [`CWD_ADDR_W-1:0]  ADDR,
  input  wire [`CWD_WORD_W-1:0]  WDATA,
  input  wire                    WR,
  input  wire                    RD,
  output wire [`CWD_WORD_W-1:0]  RDATA,
  input  wire                    PROG_WE,
  input  wire [`CWD_ADDR_W-1:0]  PROG_ADDR,
  input  wire [`CWD_WORD_W-1:0]  PROG_DATA,
  input  wire                    BULK_ERASE,
  input  wire                    SLEEP,
  input  wire                    WATCHDOG_SOFT_ENABLE,
  output reg  [2:0]              CLK_SOURCE,
  output reg  [1:0]              EXT_CLOCK_POWER,
  output reg                     EXT_CLOCK_INPUT_PIN_IS_IO,
  output reg                     CONFIG_INVALID,
  output reg                     READ_PROTECT,
  output reg                     POWER_UP_DELAY_TIMER_EN,
  output reg  [1:0]              SUPPLY_DROP_RESET_MODE,
  output reg  [1:0]              WATCHDOG_CLK_SRC,
  output reg                     WATCHDOG_WIN_SOFT,
  output reg  [2:0]              WATCHDOG_WIN_POR,
  output reg                     WATCHDOG_KEYED_CLEAR,
  output reg                     WATCHDOG_LOW_WIN_ALLOWED,
  output reg                     WATCHDOG_PER_SOFT,
  output reg  [4:0]              WATCHDOG_PER_POR,
  output reg  [4:0]              WATCHDOG_PER_EXP,
  output wire                    WATCHDOG_RUN
);
  wire [`CWD_WORD_W-1:0] word_one;
  wire [`CWD_WORD_W-1:0] word_three;
  wire [`CWD_WORD_W-1:0] store_rd;
  wire [1:0]             wdt_src;
  wire                   win_soft;
  wire [2:0]             win_por;
  wire                   per_soft;
  wire [4:0]             per_por;
  wire [4:0]             per_exp;
  reg  [1:0]             wen_ff;
  reg                    rd_pend_ff;
  reg                    stat_rd_ff;
  reg  [2:0]             osc_field;
  reg  [2:0]             nxt_clk_source;
  reg  [1:0]             nxt_ext_power;
  reg                    nxt_pin_io;
  reg                    nxt_invalid;
  reg                    run_sel;

  cwd_fuse_store u_store (
    .clk        (REF_CLK),
    .rst        (RST),
    .prog_we    (PROG_WE),
    .prog_addr  (PROG_ADDR),
    .prog_data  (PROG_DATA),
    .bulk_erase (BULK_ERASE),
    .rd_addr    (ADDR),
    .rd_data_ff (store_rd),
    .word_one   (word_one),
    .word_two   (),
    .word_three (word_three)
  );

  cwd_wdt_decode u_wdt (
    .clk_fuse (word_three[`CWD_WCS_HI:`CWD_WCS_LO]),
    .win_fuse (word_three[`CWD_WWS_HI:`CWD_WWS_LO]),
    .en_fuse  (word_three[`CWD_WEN_HI:`CWD_WEN_LO]),
    .per_fuse (word_three[`CWD_WPS_HI:`CWD_WPS_LO]),
    .wdt_src  (wdt_src),
    .win_soft (win_soft),
    .win_por  (win_por),
    .per_soft (per_soft),
    .per_por  (per_por),
    .per_exp  (per_exp)
  );

  always @* begin
    osc_field      = word_one[`CWD_OSC_HI:`CWD_OSC_LO];
    nxt_clk_source = `CWD_CLK_BAD;
    nxt_ext_power  = 2'h0;
    nxt_pin_io     = 1'b0;
    nxt_invalid    = 1'b0;
    case (osc_field)
      `CWD_OSC_ECH: begin
        nxt_clk_source = `CWD_CLK_EXT;
        nxt_ext_power  = 2'h2;
      end
      `CWD_OSC_ECM: begin
        nxt_clk_source = `CWD_CLK_EXT;
        nxt_ext_power  = 2'h1;
      end
      `CWD_OSC_ECL: begin
        nxt_clk_source = `CWD_CLK_EXT;
        nxt_ext_power  = 2'h0;
      end
      `CWD_OSC_INT: begin
        nxt_clk_source = `CWD_CLK_INT;
        nxt_pin_io     = 1'b1;
      end
      `CWD_OSC_HS: begin
        nxt_clk_source = `CWD_CLK_XTAL;
      end
      default: begin
        // Reserved codes flagged so reset logic can hold the part
        nxt_invalid = 1'b1;
      end
    endcase
  end

  // Sampled only while reset is held, frozen afterwards
  always @(posedge REF_CLK) begin
    if (RST) begin
      CLK_SOURCE                <= nxt_clk_source;
      EXT_CLOCK_POWER           <= nxt_ext_power;
      EXT_CLOCK_INPUT_PIN_IS_IO <= nxt_pin_io;
      CONFIG_INVALID            <= nxt_invalid | (wdt_src == `CWD_WSRC_BAD);
      READ_PROTECT              <= ~word_one[`CWD_PROT_BIT];
      // Timer follows only its own bit, never the brown-out field
      POWER_UP_DELAY_TIMER_EN   <= ~word_one[`CWD_POWER_UP_DELAY_TIMER_BIT];
      SUPPLY_DROP_RESET_MODE    <= word_one[`CWD_BOR_HI:`CWD_BOR_LO];
      WATCHDOG_CLK_SRC          <= wdt_src;
      WATCHDOG_WIN_SOFT         <= win_soft;
      WATCHDOG_WIN_POR          <= win_por;
      WATCHDOG_KEYED_CLEAR      <= ~win_soft;
      WATCHDOG_LOW_WIN_ALLOWED  <= win_soft;
      WATCHDOG_PER_SOFT         <= per_soft;
      WATCHDOG_PER_POR          <= per_por;
      WATCHDOG_PER_EXP          <= per_exp;
      wen_ff                    <= word_three[`CWD_WEN_HI:`CWD_WEN_LO];
    end
  end

  always @* begin
    case (wen_ff)
      `CWD_WEN_ALWAYS: run_sel = 1'b1;
      `CWD_WEN_AWAKE:  run_sel = ~SLEEP;
      `CWD_WEN_SOFT:   run_sel = WATCHDOG_SOFT_ENABLE;
      default:         run_sel = 1'b0;
    endcase
  end
  // Held off during reset so the watchdog never starts early
  assign WATCHDOG_RUN = run_sel & ~RST;

  // Read-only port; writes are ignored, data valid only the cycle after RD
  always @(posedge REF_CLK) begin
    if (RST) begin
      rd_pend_ff <= 1'b0;
      stat_rd_ff <= 1'b0;
    end else begin
      rd_pend_ff <= RD & ~WR;
      stat_rd_ff <= RD & (ADDR == `CWD_IDX_STATUS);
    end
  end

  // Status word shows the latched invalid flag and protection state
  assign RDATA = !rd_pend_ff ? {`CWD_WORD_W{1'b0}} :
                 stat_rd_ff  ? {12'h000, READ_PROTECT, CONFIG_INVALID} : store_rd;
endmodule
`default_nettype wire

/* cwd_config_chk.sv */
// Purpose: Port checks for cwd_config_decoder
// Assumes: One clock, RST synchronous active high
// Notes:   Bound to the decoder top at the foot of this file
`timescale 1ns/1ns
`default_nettype none
`include "cwd_consts.vh"
module cwd_config_chk (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic [1:0]  ADDR,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [13:0] RDATA,
  input wire logic [2:0]  CLK_SOURCE,
  input wire logic        CONFIG_INVALID,
  input wire logic        WATCHDOG_WIN_SOFT,
  input wire logic [2:0]  WATCHDOG_WIN_POR,
  input wire logic        WATCHDOG_KEYED_CLEAR,
  input wire logic        WATCHDOG_LOW_WIN_ALLOWED,
  input wire logic        WATCHDOG_PER_SOFT,
  input wire logic [4:0]  WATCHDOG_PER_POR,
  input wire logic [4:0]  WATCHDOG_PER_EXP,
  input wire logic        WATCHDOG_RUN
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_rd_one;
    RD && !WR && ADDR == `CWD_IDX_ONE;
  endsequence
  sequence s_rd_three;
    RD && !WR && ADDR == `CWD_IDX_THREE;
  endsequence
  AST_RD_ONE: assert property (s_rd_one |=> &(RDATA | ~`CWD_W1_UNIMP))
    else $error("word one spare bits not one");
  AST_RD_THREE: assert property (s_rd_three |=> RDATA[7])
    else $error("word three bit 7 not one");
  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 14'h0)
    else $error("read data without read");
  AST_INVALID: assert property (CLK_SOURCE == `CWD_CLK_BAD |-> CONFIG_INVALID)
    else $error("reserved clock code not flagged");
  AST_KEYED: assert property (WATCHDOG_KEYED_CLEAR != WATCHDOG_WIN_SOFT)
    else $error("keyed clear disagrees with window control");
  AST_LOW_WIN: assert property (WATCHDOG_LOW_WIN_ALLOWED == WATCHDOG_WIN_SOFT)
    else $error("low window offered wrongly");
  AST_WIN_POR: assert property (WATCHDOG_WIN_SOFT == (WATCHDOG_WIN_POR == 3'h7))
    else $error("window value wrong for control");
  AST_PER_EXP: assert property (WATCHDOG_PER_EXP == WATCHDOG_PER_POR + 5'h05 &&
    (!WATCHDOG_PER_SOFT || WATCHDOG_PER_POR == 5'h0b)) else $error("period decode wrong");
  AST_HOLD: assert property ($past(!RST) |-> $stable({CLK_SOURCE, WATCHDOG_WIN_POR,
    WATCHDOG_PER_POR, CONFIG_INVALID})) else $error("decoded control moved");
  AST_RUN_RST: assert property (disable iff (1'b0) RST |-> !WATCHDOG_RUN)
    else $error("watchdog runs in reset");
endmodule
bind cwd_config_decoder cwd_config_chk u_cwd_config_chk (.REF_CLK(REF_CLK), .RST(RST),
  .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .CLK_SOURCE(CLK_SOURCE),
  .CONFIG_INVALID(CONFIG_INVALID), .WATCHDOG_WIN_SOFT(WATCHDOG_WIN_SOFT),
  .WATCHDOG_WIN_POR(WATCHDOG_WIN_POR), .WATCHDOG_KEYED_CLEAR(WATCHDOG_KEYED_CLEAR),
  .WATCHDOG_LOW_WIN_ALLOWED(WATCHDOG_LOW_WIN_ALLOWED), .WATCHDOG_PER_SOFT(WATCHDOG_PER_SOFT),
  .WATCHDOG_PER_POR(WATCHDOG_PER_POR), .WATCHDOG_PER_EXP(WATCHDOG_PER_EXP),
  .WATCHDOG_RUN(WATCHDOG_RUN));
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for cwd_config_decoder
// Assumes: Read data one cycle after RD
// Notes:   Fuses reach the controls only through a reset
`timescale 1ns/1ns
`default_nettype none
`include "cwd_consts.vh"
module tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd = 1'b0, wr = 1'b0, pwe = 1'b0, ers = 1'b0, slp = 1'b0, watchdog_soft_enable = 1'b0;
  logic        rd_d = 1'b0, ev;
  logic [1:0]  addr = 2'h0;
  logic [13:0] dat = 14'h0, w1, w3;
  logic [27:0] exp_q[$], pend;
  logic [2:0]  src;
  logic [1:0]  ws;
  logic [4:0]  por;
  logic [4:0]  ptab[8] = '{5'h00, 5'h12, 5'h13, 5'h1f, 5'h1e, 5'h05, 5'h0b, 5'h11};
  wire  [13:0] rdata;
  wire  [2:0]  clk_src, win_por;
  wire  [1:0]  ext_pwr, bor, wsrc;
  wire  [4:0]  per_por, per_exp;
  wire         pin_io, inv, prot, power_up_delay_timer, wsoft, keyed, loww, psoft, run;
  int          err_count = 0, samples_checked = 0, i, j, seed;
  always #5 ref_clk = ~ref_clk;
  cwd_config_decoder u_cwd_config_decoder (.REF_CLK(ref_clk), .RST(rst), .ADDR(addr),
    .WDATA(dat), .WR(wr), .RD(rd), .RDATA(rdata), .PROG_WE(pwe), .PROG_ADDR(addr),
    .PROG_DATA(dat), .BULK_ERASE(ers), .SLEEP(slp), .WATCHDOG_SOFT_ENABLE(watchdog_soft_enable),
    .CLK_SOURCE(clk_src), .EXT_CLOCK_POWER(ext_pwr), .EXT_CLOCK_INPUT_PIN_IS_IO(pin_io),
    .CONFIG_INVALID(inv), .READ_PROTECT(prot), .POWER_UP_DELAY_TIMER_EN(power_up_delay_timer),
    .SUPPLY_DROP_RESET_MODE(bor), .WATCHDOG_CLK_SRC(wsrc), .WATCHDOG_WIN_SOFT(wsoft),
    .WATCHDOG_WIN_POR(win_por), .WATCHDOG_KEYED_CLEAR(keyed),
    .WATCHDOG_LOW_WIN_ALLOWED(loww), .WATCHDOG_PER_SOFT(psoft),
    .WATCHDOG_PER_POR(per_por), .WATCHDOG_PER_EXP(per_exp), .WATCHDOG_RUN(run));
  task automatic cmp(input string nm, input logic [13:0] e, input logic [13:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d, mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Strobes all set here so two tasks never drive one signal in one step
  task automatic bus(input logic [3:0] s, input logic [1:0] a, input logic [13:0] d);
    {rd, wr, pwe, ers} <= s;
    addr <= a;
    dat <= d;
    @(posedge ref_clk);
  endtask
  task automatic rdw(input logic [1:0] a, input logic [13:0] e, input logic [13:0] m);
    exp_q.push_back({m, e});
    bus(4'h8, a, 14'h0);
  endtask
  task automatic do_rst();
    rst <= 1'b1;
    bus(4'h0, 2'h0, 14'h0);
    bus(4'h0, 2'h0, 14'h0);
    rst <= 1'b0;
    bus(4'h0, 2'h0, 14'h0);
  endtask
  always @(posedge ref_clk) begin
    if (rd_d) begin
      pend = exp_q.pop_front();
      cmp("rdata", pend[13:0], rdata & pend[27:14]);
    end
    rd_d <= rd && !rst;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    $display("[FAIL] run timed out");
    end_of_test();
  end
  initial begin
    seed = $urandom(32'hcb85);
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    bus(4'h4, 2'h0, 14'h0);
    rdw(2'h0, 14'h3fff, 14'h3fff);
    rdw(2'h1, 14'h3fff, 14'h3fff);
    rdw(2'h2, 14'h0fff, 14'h3fff);
    // Read beside a write is refused and returns zero
    exp_q.push_back({14'h3fff, 14'h0});
    bus(4'hc, 2'h0, 14'h0);
    bus(4'h0, 2'h0, 14'h0);
    cmp("wsrc", `CWD_WSRC_MF, wsrc);
    $display("test erased done");
    for (i = 0; i < 8; i++) begin
      w1 = 14'($urandom);
      w3 = 14'($urandom);
      w1[2:0] = i[2:0];
      w3[10:8] = i[2:0];
      w3[6:5] = i[1:0];
      w3[4:0] = ptab[i];
      w3[13:11] = {i[0], i[1], i[2]};
      ws = (w3[13:11] == 3'h7) ? `CWD_WSRC_SOFT : (w3[13:11] == 3'h1) ? `CWD_WSRC_MF :
           (w3[13:11] == 3'h0) ? `CWD_WSRC_LF : `CWD_WSRC_BAD;
      bus(4'h1, 2'h0, 14'h0);
      bus(4'h2, 2'h0, w1);
      bus(4'h2, 2'h2, w3);
      do_rst();
      rdw(2'h0, w1 | `CWD_W1_UNIMP, 14'h3fff);
      rdw(2'h2, w3 | `CWD_W3_UNIMP, 14'h3fff);
      rdw(2'h3, {12'h0, !w1[7], (i < 4 && i != 2) || ws == 2'h3}, 14'h0003);
      bus(4'h0, 2'h0, 14'h0);
      src = (i > 4) ? `CWD_CLK_EXT : (i == 4) ? `CWD_CLK_INT : (i == 2) ? `CWD_CLK_XTAL : 3'h7;
      cmp("clk_src", src, clk_src);
      if (i > 4) cmp("ext_pwr", 14'(i - 5), ext_pwr);
      cmp("pin_io", i == 4, pin_io);
      cmp("prot", !w1[7], prot);
      cmp("power_up_delay_timer", !w1[5], power_up_delay_timer);
      cmp("bor", w1[10:9], bor);
      cmp("wsrc", ws, wsrc);
      cmp("wsoft", i > 5, wsoft);
      cmp("win_por", (i > 5) ? 3'h7 : i[2:0], win_por);
      cmp("keyed", i < 6, keyed);
      cmp("low_win", i > 5, loww);
      por = (w3[4:0] == 5'h1f) ? 5'h0b : (w3[4:0] > 5'h12) ? 5'h00 : w3[4:0];
      cmp("psoft", w3[4:0] == 5'h1f, psoft);
      cmp("per_por", por, per_por);
      cmp("per_exp", por + 5'h05, per_exp);
      for (j = 0; j < 4; j++) begin
        slp <= j[0];
        watchdog_soft_enable <= j[1];
        @(posedge ref_clk);
        ev = i[1:0] == 2'h3 || (i[1:0] == 2'h2 && !j[0]) || (i[1:0] == 2'h1 && j[1]);
        cmp("run", ev, run);
      end
      bus(4'h2, 2'h0, 14'h0);
      bus(4'h0, 2'h0, 14'h0);
      cmp("clk_hold", src, clk_src);
      bus(4'h2, 2'h0, 14'h3fff);
      do_rst();
      cmp("prot_kept", 14'h1, prot);
      cmp("clk_new", 14'h0, clk_src);
      $display("test %0d done", i);
    end
    bus(4'h1, 2'h0, 14'h0);
    do_rst();
    cmp("prot_erased", 14'h0, prot);
    repeat (3) bus(4'h0, 2'h0, 14'h0);
    cmp("queue", 14'h0, 14'(exp_q.size()));
    end_of_test();
  end
endmodule
`default_nettype wire
